// >>> src/spc_pkg.sv
// Register map, field positions and reset values of the SCSI parity control block
package spc_pkg;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned REG_W      = 8;
   localparam int unsigned LB_W       = 11;
   localparam int unsigned PIN_W      = 10;

   localparam logic [7:0]  OFF_CTRL0  = 8'h00;
   localparam logic [7:0]  OFF_CTRL1  = 8'h04;
   localparam logic [7:0]  OFF_XFER   = 8'h08;
   localparam logic [7:0]  OFF_IRQEN  = 8'h0C;
   localparam logic [7:0]  OFF_TEST4  = 8'h10;
   localparam logic [7:0]  OFF_STAT0  = 8'h14;
   localparam logic [7:0]  OFF_LBDRV  = 8'h18;
   localparam logic [7:0]  OFF_LBSMP  = 8'h1C;

   localparam int unsigned CTRL0_ATN  = 1;
   localparam int unsigned CTRL0_GEN  = 2;
   localparam int unsigned CTRL0_CHK  = 3;
   localparam int unsigned CTRL1_EVEN = 2;
   localparam int unsigned CTRL1_BAD  = 4;
   localparam int unsigned XFER_HALT  = 7;
   localparam int unsigned IRQ_PERR   = 0;
   localparam int unsigned IRQ_HALT   = 1;
   localparam int unsigned TEST4_LOOP = 3;
   localparam int unsigned LB_PAR     = 8;
   localparam int unsigned LB_ATN     = 9;
   localparam int unsigned LB_OE      = 10;
   localparam int unsigned PIN_ATN    = 9;

   localparam logic [7:0]  CTRL0_MASK = 8'h0E;
   localparam logic [7:0]  CTRL1_MASK = 8'h14;
   localparam logic [7:0]  XFER_MASK  = 8'h80;
   localparam logic [7:0]  IRQ_MASK   = 8'h03;
   localparam logic [7:0]  TEST4_MASK = 8'h08;
   localparam logic [7:0]  REG_RST    = 8'h00;
   localparam logic [10:0] LB_RST     = 11'h000;
endpackage

// >>> src/spc_parity_ctrl.sv
// SCSI parity generation, checking and error response with APB registers
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Contract
// [RULE1] With attention-on-error set, an initiator raises ATN when it detects a parity error.
// [RULE2] Parity generation enable picks generated parity or pass-through parity toward SCSI.
// [RULE3] Parity errors are flagged only while parity checking is enabled.
// [RULE4] Received bytes are checked for odd parity; an even count of ones is an error.
// [RULE5] The even-parity select makes generated SCSI parity even when set, odd when clear.
// [RULE6] In target mode the halt control decides whether a parity error or ATN halts at once.
// [RULE7] A parity error interrupt is requested only when its interrupt enable bit is set.
// [RULE8] Loopback enable gives software drive and sampling of every SCSI signal in any role.
// [RULE9] Software can send one byte carrying deliberately wrong parity onto the SCSI bus.
// [RULE10] Any parity error on the SCSI or system side sets the parity error status flag; system-side bytes are checked only while generation is off.
// The flag is set only while parity checking is enabled, as in RULE3.
module spc_parity_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        role_initiator,
   input  wire logic        scsi_drive,
   input  wire logic        sys_tx_valid,
   input  wire logic [7:0]  sys_tx_data,
   input  wire logic        sys_tx_par,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_par,
   output logic             sys_rx_valid,
   output logic [7:0]       sys_rx_data,
   output logic             sys_rx_par,
   output logic             halt,
   input  wire logic [7:0]  scsi_db_i,
   input  wire logic        scsi_dp_i,
   input  wire logic        scsi_atn_i,
   output logic [7:0]       scsi_db_o,
   output logic             scsi_dp_o,
   output logic             scsi_db_oe,
   output logic             scsi_atn_o,
   output logic             scsi_atn_oe
);

   typedef struct packed {
      logic [7:0]  ctrl0;
      logic [7:0]  ctrl1;
      logic [7:0]  xfer;
      logic [7:0]  irqen;
      logic [7:0]  test4;
      logic [7:0]  stat;
      logic [10:0] lbdrv;
      logic [9:0]  sync1;
      logic [9:0]  sync2;
      logic        atn_d;
      logic        atn_hold;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq;
      logic        halt;
      logic [7:0]  db_o;
      logic        dp_o;
      logic        db_oe;
      logic        atn_o;
      logic        atn_oe;
      logic        rx_v;
      logic [7:0]  rx_d;
      logic        rx_p;
   } spc_state_s;

   spc_state_s r;
   spc_state_s next_r;

   // True when nine bits hold an odd count of ones
   function automatic logic spc_odd_ok(input logic [7:0] d, input logic p);
      spc_odd_ok = ^{d, p};
   endfunction

   function automatic logic spc_hit(input logic [7:0] a);
      spc_hit = (a == spc_pkg::OFF_CTRL0) || (a == spc_pkg::OFF_CTRL1) ||
                (a == spc_pkg::OFF_XFER)  || (a == spc_pkg::OFF_IRQEN) ||
                (a == spc_pkg::OFF_TEST4) || (a == spc_pkg::OFF_STAT0) ||
                (a == spc_pkg::OFF_LBDRV) || (a == spc_pkg::OFF_LBSMP);
   endfunction

   logic gen_en;
   logic chk_en;
   logic even_sel;
   logic bad_sel;
   logic loop_en;
   logic perr_evt;
   logic atn_rise;
   logic halt_evt;
   logic wr_fire;
   logic gen_par;
   logic [7:0] w1c;
   logic [7:0] evts;
   logic [31:0] rdata;

   always_comb begin
      next_r   = r;
      gen_en   = r.ctrl0[spc_pkg::CTRL0_GEN];
      chk_en   = r.ctrl0[spc_pkg::CTRL0_CHK];
      even_sel = r.ctrl1[spc_pkg::CTRL1_EVEN];
      bad_sel  = r.ctrl1[spc_pkg::CTRL1_BAD];
      loop_en  = r.test4[spc_pkg::TEST4_LOOP];
      w1c      = 8'h00;
      evts     = 8'h00;
      rdata    = 32'h00000000;
      gen_par  = 1'b0;

      // Pins cross in two stages; only the second stage feeds logic
      next_r.sync1 = {scsi_atn_i, scsi_dp_i, scsi_db_i};
      next_r.sync2 = r.sync1;
      next_r.atn_d = r.sync2[spc_pkg::PIN_ATN];
      atn_rise     = r.sync2[spc_pkg::PIN_ATN] & ~r.atn_d;

      // System-side check only applies while parity flows through
      perr_evt = chk_en & ((rx_valid & ~spc_odd_ok(rx_data, rx_par)) |      // [RULE3] [RULE4]
                 (sys_tx_valid & ~gen_en & ~spc_odd_ok(sys_tx_data, sys_tx_par)));
      halt_evt = ~role_initiator & r.xfer[spc_pkg::XFER_HALT] & (perr_evt | atn_rise); // [RULE6]
      evts[spc_pkg::IRQ_PERR] = perr_evt;                                   // [RULE10]
      evts[spc_pkg::IRQ_HALT] = halt_evt;
      next_r.halt = halt_evt;                                               // [RULE6]

      // Transmit path; the forced bad parity is consumed by one byte
      if (sys_tx_valid) begin
         gen_par = gen_en ? (^sys_tx_data ^ ~even_sel) : sys_tx_par;        // [RULE2] [RULE5]
         next_r.db_o = sys_tx_data;
         next_r.dp_o = bad_sel ? ~gen_par : gen_par;                        // [RULE9]
         next_r.ctrl1[spc_pkg::CTRL1_BAD] = 1'b0;
      end
      next_r.db_oe = scsi_drive;

      // Receive path toward the system side
      next_r.rx_v = rx_valid;
      if (rx_valid) begin
         next_r.rx_d = rx_data;
         next_r.rx_p = gen_en ? ~(^rx_data) : rx_par;                       // [RULE2]
      end

      // APB: one wait state, answer registered
      rdata = 32'h00000000;
      unique case (paddr)
         spc_pkg::OFF_CTRL0: rdata = {24'h000000, r.ctrl0};
         spc_pkg::OFF_CTRL1: rdata = {24'h000000, r.ctrl1};
         spc_pkg::OFF_XFER:  rdata = {24'h000000, r.xfer};
         spc_pkg::OFF_IRQEN: rdata = {24'h000000, r.irqen};
         spc_pkg::OFF_TEST4: rdata = {24'h000000, r.test4};
         spc_pkg::OFF_STAT0: rdata = {24'h000000, r.stat};
         spc_pkg::OFF_LBDRV: rdata = {21'h0, r.lbdrv};
         spc_pkg::OFF_LBSMP: rdata = {22'h0, r.sync2};                      // [RULE8]
         default:            rdata = 32'h00000000;
      endcase
      if (psel && penable && !r.pready) begin
         next_r.pready  = 1'b1;
         next_r.prdata  = pwrite ? 32'h00000000 : rdata;
         next_r.pslverr = ~spc_hit(paddr);
      end else begin
         next_r.pready  = 1'b0;
         next_r.prdata  = 32'h00000000;
         next_r.pslverr = 1'b0;
      end
      wr_fire = psel & penable & r.pready & pwrite;
      if (wr_fire) begin
         unique case (paddr)
            spc_pkg::OFF_CTRL0: next_r.ctrl0 = pwdata[7:0] & spc_pkg::CTRL0_MASK;
            spc_pkg::OFF_CTRL1: next_r.ctrl1 = pwdata[7:0] & spc_pkg::CTRL1_MASK;
            spc_pkg::OFF_XFER:  next_r.xfer  = pwdata[7:0] & spc_pkg::XFER_MASK;
            spc_pkg::OFF_IRQEN: next_r.irqen = pwdata[7:0] & spc_pkg::IRQ_MASK;
            spc_pkg::OFF_TEST4: next_r.test4 = pwdata[7:0] & spc_pkg::TEST4_MASK;
            spc_pkg::OFF_STAT0: w1c          = pwdata[7:0] & spc_pkg::IRQ_MASK;
            spc_pkg::OFF_LBDRV: next_r.lbdrv = pwdata[10:0];
            default:            w1c          = 8'h00;
         endcase
      end
      // A new event in the clearing cycle wins over the clear
      next_r.stat = (r.stat & ~w1c) | evts;                                 // [RULE10]
      next_r.irq  = |(next_r.stat & next_r.irqen);                          // [RULE7]

      // ATN stays up until software clears the parity error flag
      next_r.atn_hold = (r.atn_hold & next_r.stat[spc_pkg::IRQ_PERR]) |
                        (role_initiator & r.ctrl0[spc_pkg::CTRL0_ATN] & perr_evt); // [RULE1]
      next_r.atn_o  = next_r.atn_hold;
      next_r.atn_oe = next_r.atn_hold;

      // Loopback hands every driven SCSI signal to software
      if (next_r.test4[spc_pkg::TEST4_LOOP]) begin                          // [RULE8]
         next_r.db_o   = next_r.lbdrv[7:0];
         next_r.dp_o   = next_r.lbdrv[spc_pkg::LB_PAR];
         next_r.db_oe  = next_r.lbdrv[spc_pkg::LB_OE];
         next_r.atn_o  = next_r.lbdrv[spc_pkg::LB_ATN];
         next_r.atn_oe = next_r.lbdrv[spc_pkg::LB_ATN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r       <= '0;
         r.ctrl0 <= spc_pkg::REG_RST;
         r.ctrl1 <= spc_pkg::REG_RST;
         r.xfer  <= spc_pkg::REG_RST;
         r.irqen <= spc_pkg::REG_RST;
         r.test4 <= spc_pkg::REG_RST;
         r.stat  <= spc_pkg::REG_RST;
         r.lbdrv <= spc_pkg::LB_RST;
      end else begin
         r <= next_r;
      end
   end

   assign pready       = r.pready;
   assign prdata       = r.prdata;
   assign pslverr      = r.pslverr;
   assign irq          = r.irq;
   assign halt         = r.halt;
   assign sys_rx_valid = r.rx_v;
   assign sys_rx_data  = r.rx_d;
   assign sys_rx_par   = r.rx_p;
   assign scsi_db_o    = r.db_o;
   assign scsi_dp_o    = r.dp_o;
   assign scsi_db_oe   = r.db_oe;
   assign scsi_atn_o   = r.atn_o;
   assign scsi_atn_oe  = r.atn_oe;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   atn_on_err_a: assert property (                                          // [RULE1]
      role_initiator && r.ctrl0[spc_pkg::CTRL0_ATN] && perr_evt && !loop_en
      && !(wr_fire && paddr == spc_pkg::OFF_TEST4) |=> scsi_atn_o && scsi_atn_oe [*2])
      else $error("ATN not raised after initiator parity error");

   pass_through_a: assert property (                                        // [RULE2]
      sys_tx_valid && !gen_en && !bad_sel && !loop_en && !wr_fire
      |=> scsi_dp_o == $past(sys_tx_par))
      else $error("Parity not passed through with generation off");

   check_off_a: assert property (                                           // [RULE3]
      !chk_en && !r.stat[spc_pkg::IRQ_PERR] && !wr_fire |=> !r.stat[spc_pkg::IRQ_PERR])
      else $error("Parity error flagged while checking disabled");

   odd_check_a: assert property (                                          // [RULE4]
      chk_en && rx_valid && !spc_odd_ok(rx_data, rx_par) |=> r.stat[spc_pkg::IRQ_PERR])
      else $error("Even parity byte not flagged");

   parity_sense_a: assert property (                                        // [RULE5]
      sys_tx_valid && gen_en && !bad_sel && !loop_en && !wr_fire
      |=> spc_odd_ok(scsi_db_o, scsi_dp_o) == !$past(even_sel))
      else $error("Generated parity has wrong sense");

   target_halt_a: assert property (                                         // [RULE6]
      ##1 halt |-> !$past(role_initiator) && $past(r.xfer[spc_pkg::XFER_HALT]))
      else $error("Halt without target mode and halt control");

   perr_irq_a: assert property (                                            // [RULE7]
      irq |-> (r.stat & r.irqen) != 8'h00)
      else $error("Interrupt without an enabled status bit");

   loop_drive_a: assert property (                                          // [RULE8]
      loop_en && $stable(r.lbdrv) && $stable(loop_en)
      |-> scsi_db_o == r.lbdrv[7:0] && scsi_dp_o == r.lbdrv[spc_pkg::LB_PAR])
      else $error("Loopback does not drive SCSI pins");

   bad_parity_a: assert property (                                          // [RULE9]
      sys_tx_valid && gen_en && bad_sel && !loop_en && !wr_fire
      |=> spc_odd_ok(scsi_db_o, scsi_dp_o) == $past(even_sel)
          && !r.ctrl1[spc_pkg::CTRL1_BAD])
      else $error("Forced bad parity not sent once");

   perr_flag_a: assert property (                                           // [RULE10]
      perr_evt |=> r.stat[spc_pkg::IRQ_PERR] ##1 (r.stat[spc_pkg::IRQ_PERR] || $past(wr_fire)))
      else $error("Parity error flag not set");

   apb_wait_a: assert property (
      psel && penable && !pready
      |=> pready)
      else $error("Access phase not answered after one wait state");

   ready_pulse_a: assert property (
      pready
      |=> !pready)
      else $error("Ready held longer than one cycle");

   unmapped_err_a: assert property (
      psel && penable && !pready && !spc_hit(paddr)
      |=> pslverr)
      else $error("Unmapped access without slave error");

   irq_level_a: assert property (                                           // [RULE7]
      (r.stat & r.irqen) != 8'h00
      |-> irq)
      else $error("Enabled status bit without interrupt");

   stat_sticky_a: assert property (                                         // [RULE10]
      r.stat[spc_pkg::IRQ_PERR] && !wr_fire
      |=> r.stat[spc_pkg::IRQ_PERR])
      else $error("Parity error flag lost without a clear");

   sys_check_a: assert property (                                           // [RULE10]
      chk_en && !gen_en && sys_tx_valid && !spc_odd_ok(sys_tx_data, sys_tx_par)
      |=> r.stat[spc_pkg::IRQ_PERR])
      else $error("System side parity error not flagged");

   halt_on_err_a: assert property (                                         // [RULE6]
      !role_initiator && r.xfer[spc_pkg::XFER_HALT] && perr_evt
      |=> halt)
      else $error("Target did not halt on parity error");

   no_halt_a: assert property (                                             // [RULE6]
      role_initiator || !r.xfer[spc_pkg::XFER_HALT]
      |=> !halt)
      else $error("Halt raised while halting is not allowed");

   atn_follow_a: assert property (                                          // [RULE1]
      !loop_en
      |-> scsi_atn_o == r.atn_hold && scsi_atn_oe == r.atn_hold)
      else $error("ATN pins do not follow the held attention");

   atn_cause_a: assert property (                                           // [RULE1]
      $rose(r.atn_hold)
      |-> $past(role_initiator && r.ctrl0[spc_pkg::CTRL0_ATN] && perr_evt))
      else $error("ATN raised without initiator parity error");

   rx_pass_a: assert property (                                             // [RULE2]
      rx_valid && !gen_en
      |=> sys_rx_valid && sys_rx_data == $past(rx_data) && sys_rx_par == $past(rx_par))
      else $error("Received byte not passed through");

   rx_gen_a: assert property (                                              // [RULE2]
      rx_valid && gen_en
      |=> sys_rx_valid && spc_odd_ok(sys_rx_data, sys_rx_par))
      else $error("Received byte without generated odd parity");

   tx_data_a: assert property (                                             // [RULE2]
      sys_tx_valid && !loop_en && !wr_fire
      |=> scsi_db_o == $past(sys_tx_data))
      else $error("Sent byte not on the data pins");

endmodule

`default_nettype wire

// >>> verification/spc_scsi_peer.sv
// SCSI bus peer model that drives the pins seen by the parity block
`timescale 1ns/1ns
`default_nettype none
module spc_scsi_peer (
   input  wire logic [7:0] db_o,
   input  wire logic       dp_o,
   input  wire logic       db_oe,
   input  wire logic       atn_o,
   input  wire logic       atn_oe,
   input  wire logic       peer_en,
   input  wire logic [7:0] peer_db,
   input  wire logic       peer_atn,
   output logic [7:0]      db_i,
   output logic            dp_i,
   output logic            atn_i
);
   // Terminated lines read deasserted once nobody drives them
   always_comb begin
      db_i  = db_oe ? db_o : (peer_en ? peer_db : 8'h00);
      dp_i  = db_oe ? dp_o : (peer_en ? ~^peer_db : 1'b0);
      atn_i = atn_oe ? atn_o : peer_atn;
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking testbench for the SCSI parity control block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic        role_initiator, scsi_drive, sys_tx_valid, sys_tx_par, rx_valid, rx_par;
   logic        sys_rx_valid, sys_rx_par, halt, scsi_dp_i, scsi_atn_i, scsi_dp_o;
   logic        scsi_db_oe, scsi_atn_o, scsi_atn_oe, peer_en, peer_atn;
   logic [7:0]  paddr, sys_tx_data, rx_data, sys_rx_data, scsi_db_i, scsi_db_o, peer_db;
   logic [31:0] pwdata, prdata, rd;
   int          bad_count, n_checks;

   spc_parity_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq(irq), .role_initiator(role_initiator),
      .scsi_drive(scsi_drive), .sys_tx_valid(sys_tx_valid), .sys_tx_data(sys_tx_data),
      .sys_tx_par(sys_tx_par), .rx_valid(rx_valid), .rx_data(rx_data), .rx_par(rx_par),
      .sys_rx_valid(sys_rx_valid), .sys_rx_data(sys_rx_data), .sys_rx_par(sys_rx_par),
      .halt(halt), .scsi_db_i(scsi_db_i), .scsi_dp_i(scsi_dp_i), .scsi_atn_i(scsi_atn_i),
      .scsi_db_o(scsi_db_o), .scsi_dp_o(scsi_dp_o), .scsi_db_oe(scsi_db_oe),
      .scsi_atn_o(scsi_atn_o), .scsi_atn_oe(scsi_atn_oe));
   spc_scsi_peer peer_u (.db_o(scsi_db_o), .dp_o(scsi_dp_o), .db_oe(scsi_db_oe),
      .atn_o(scsi_atn_o), .atn_oe(scsi_atn_oe), .peer_en(peer_en), .peer_db(peer_db),
      .peer_atn(peer_atn), .db_i(scsi_db_i), .dp_i(scsi_dp_i), .atn_i(scsi_atn_i));

   always #50 pclk = ~pclk;

   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask

   // Request is held until pready is sampled high; no fixed wait is assumed
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task send(input logic [7:0] d, input logic p);
      @(posedge pclk);
      sys_tx_valid <= 1'b1; sys_tx_data <= d; sys_tx_par <= p;
      @(posedge pclk);
      sys_tx_valid <= 1'b0;
      #1;
   endtask

   task recv(input logic [7:0] d, input logic p);
      @(posedge pclk);
      rx_valid <= 1'b1; rx_data <= d; rx_par <= p;
      @(posedge pclk);
      rx_valid <= 1'b0;
      #1;
   endtask

   task settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task t_regs();
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", rd, 32'h0);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rd[30:0], er}, 32'h1);
      apb(1'b1, spc_pkg::OFF_CTRL0, 32'hFF);
      apb(1'b0, spc_pkg::OFF_CTRL0, 32'h0);
      chk("ctrl0 mask", rd, 32'(spc_pkg::CTRL0_MASK));
   endtask

   // Pass-through byte has wrong parity on purpose, so checking must stay off here
   task t_gen();
      logic [7:0] d;
      scsi_drive <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         d = (i == 2) ? 8'h03 : 8'h07;
         apb(1'b1, spc_pkg::OFF_CTRL0, (i < 2) ? 32'h4 : 32'h0);
         apb(1'b1, spc_pkg::OFF_CTRL1, (i == 1) ? 32'h4 : 32'h0);
         send(d, i < 2);
         chk("db out", 32'(scsi_db_o), 32'(d));
         chk("dp out", 32'(scsi_dp_o), (i == 1) ? 32'h1 : 32'h0);
      end
      chk("db oe", 32'(scsi_db_oe), 32'h1);
   endtask

   task t_bad();
      apb(1'b1, spc_pkg::OFF_CTRL0, 32'h4);
      apb(1'b1, spc_pkg::OFF_CTRL1, 32'h10);
      send(8'h07, 1'b1);
      chk("bad dp", 32'(scsi_dp_o), 32'h1);
      send(8'h07, 1'b1);
      chk("next dp", 32'(scsi_dp_o), 32'h0);
      apb(1'b0, spc_pkg::OFF_CTRL1, 32'h0);
      chk("bad bit clear", rd, 32'h0);
      recv(8'h03, 1'b0);
      chk("rx gen par", 32'({sys_rx_par, sys_rx_data}), 32'h103);
   endtask

   task t_chk();
      apb(1'b1, spc_pkg::OFF_CTRL0, 32'h0);
      recv(8'h03, 1'b0);
      apb(1'b0, spc_pkg::OFF_STAT0, 32'h0);
      chk("no check", rd, 32'h0);
      apb(1'b1, spc_pkg::OFF_CTRL0, 32'h8);
      recv(8'h03, 1'b1);
      chk("rx par", 32'({sys_rx_valid, sys_rx_par, sys_rx_data}), 32'h303);
      apb(1'b0, spc_pkg::OFF_STAT0, 32'h0);
      chk("good byte", rd, 32'h0);
      recv(8'h03, 1'b0);
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b0, spc_pkg::OFF_STAT0, 32'h0);
      chk("scsi error", rd, 32'h1);
      apb(1'b1, spc_pkg::OFF_IRQEN, 32'h1);
      settle();
      chk("irq on", 32'(irq), 32'h1);
      apb(1'b1, spc_pkg::OFF_STAT0, 32'h1);
      settle();
      chk("irq off", 32'(irq), 32'h0);
      send(8'h03, 1'b0);
      apb(1'b0, spc_pkg::OFF_STAT0, 32'h0);
      chk("sys error", rd, 32'h1);
      apb(1'b1, spc_pkg::OFF_STAT0, 32'h1);
   endtask

   task t_resp();
      int k;
      apb(1'b1, spc_pkg::OFF_CTRL0, 32'hA);
      apb(1'b1, spc_pkg::OFF_XFER, 32'h80);
      role_initiator <= 1'b1;
      recv(8'h03, 1'b0);
      chk("atn init", 32'({scsi_atn_o, scsi_atn_oe, halt}), 32'h6);
      apb(1'b1, spc_pkg::OFF_STAT0, 32'h3);
      role_initiator <= 1'b0;
      settle();
      chk("atn off", 32'({scsi_atn_o, scsi_atn_oe}), 32'h0);
      recv(8'h03, 1'b0);
      chk("halt", 32'({scsi_atn_o, halt}), 32'h1);
      settle();
      chk("halt pulse", 32'(halt), 32'h0);
      apb(1'b0, spc_pkg::OFF_STAT0, 32'h0);
      chk("halt status", rd, 32'h3);
      apb(1'b1, spc_pkg::OFF_STAT0, 32'h3);
      // ATN from the far side reaches logic through the pin synchroniser
      peer_atn <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         #1;
         k++;
      end while (halt !== 1'b1 && k < 8);
      chk("atn halt", 32'(halt), 32'h1);
      @(posedge pclk);
      peer_atn <= 1'b0;
      apb(1'b1, spc_pkg::OFF_XFER, 32'h0);
      apb(1'b1, spc_pkg::OFF_STAT0, 32'h3);
      recv(8'h03, 1'b0);
      chk("no halt", 32'(halt), 32'h0);
      apb(1'b1, spc_pkg::OFF_STAT0, 32'h3);
   endtask

   task t_loop();
      peer_en <= 1'b1; peer_db <= 8'hC3; scsi_drive <= 1'b0;
      settle();
      apb(1'b0, spc_pkg::OFF_LBSMP, 32'h0);
      chk("peer sample", rd, 32'h1C3);
      peer_en <= 1'b0;
      apb(1'b1, spc_pkg::OFF_TEST4, 32'h8);
      apb(1'b1, spc_pkg::OFF_LBDRV, 32'h75A);
      settle();
      chk("lb drive", 32'({scsi_db_oe, scsi_atn_oe, scsi_atn_o, scsi_dp_o, scsi_db_o}),
          32'hF5A);
      apb(1'b0, spc_pkg::OFF_LBSMP, 32'h0);
      chk("lb sample", rd, 32'h35A);
   endtask

   task results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Whole run is a few hundred cycles, so this margin only trips on a hang
   initial begin
      #1000000;
      bad_count++;
      results();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, role_initiator, scsi_drive} = 7'h00;
      {sys_tx_valid, sys_tx_par, rx_valid, rx_par, peer_en, peer_atn} = 6'h00;
      {paddr, sys_tx_data, rx_data, peer_db, pwdata} = 64'h0;
      bad_count = 0;
      n_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_gen();
      t_bad();
      t_chk();
      t_resp();
      t_loop();
      results();
   end
endmodule
`default_nettype wire
